// *** src/ppi_pad_ctl.sv ***
// combinational pad drive and pull-up gating for a group of pins
// assumes registered controls from the core; output enable active low
`timescale 1ns/1ps
module ppi_pad_ctl (
  ppi_pad_if.pad p
);
  // drive and pull-up per pin
  always_comb begin
    for (int i = 0; i < $bits(p.outVal); i++) begin
      p.padOut[i] = 1'b0;
      if (!p.isOut[i]) begin
        p.padOeN[i]  = 1'b1;
        p.padPull[i] = p.pullEn[i];
      end else if (p.openDrain[i]) begin
        // only low is driven
        p.padOeN[i]  = p.outVal[i];
        // low drops pull-up, high keeps enable
        p.padPull[i] = p.outVal[i] & p.pullEn[i];
      end else begin
        p.padOut[i]  = p.outVal[i];
        p.padOeN[i]  = 1'b0;
        p.padPull[i] = 1'b0; // push-pull never pulls
      end
    end
  end
endmodule

// *** src/ppi_pad_if.sv ***
// interface between the pad core and its per-pin pad control leaf
// assumes one clock domain
`timescale 1ns/1ps
interface ppi_pad_if #(parameter int N = 6);
  logic [N-1:0] outVal;
  logic [N-1:0] isOut;
  logic [N-1:0] openDrain;
  logic [N-1:0] pullEn;
  logic [N-1:0] padOut;
  logic [N-1:0] padOeN;
  logic [N-1:0] padPull;
  modport core (output outVal, isOut, openDrain, pullEn,
                input padOut, padOeN, padPull);
  modport pad  (input outVal, isOut, openDrain, pullEn,
                output padOut, padOeN, padPull);
endinterface

// *** src/ppi_pad_pullup_irq.sv ***
// pad pull-up control, timer/port pin mux and external interrupt inputs
// assumes wishbone classic master on mclk, pins asynchronous to mclk
`timescale 1ns/1ps
`include "ppi_regs.svh"
module ppi_pad_pullup_irq #(
  parameter int NPORT = 6
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic              wb_we_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  output logic                   wb_err_o,
  input  wire logic              lowPowerMode,
  input  wire logic [NPORT-1:0]  timerOut,
  input  wire logic [NPORT-1:0]  timerOutEn,
  output logic      [NPORT-1:0]  timerIn,
  input  wire logic [NPORT-1:0]  portPinIn,
  output logic      [NPORT-1:0]  portPinOut,
  output logic      [NPORT-1:0]  portPinOeN,
  output logic      [NPORT-1:0]  portPinPull,
  output logic                   busTxOut,
  output logic                   busTxOeN,
  output logic                   busTxPull,
  input  wire logic              busTxData,
  output logic                   busRxPull,
  input  wire logic              extIntReqAN,
  input  wire logic              extIntReqBN,
  output logic                   extIntPull,
  output logic      [1:0]        extIntReq,
  output logic                   irq
);
  logic [NPORT-1:0] funcTimer_reg;
  logic [NPORT-1:0] portDir_reg;
  logic [NPORT-1:0] portData_reg;
  logic [NPORT-1:0] portPullEn_reg;
  logic [NPORT-1:0] portOd_reg;
  logic [1:0]       sysPud_reg;
  logic [1:0]       intEdge_reg;
  logic [1:0]       intStat_reg;
  logic [1:0]       intStat_next;
  logic [1:0]       intMask_reg;
  logic [1:0]       txCfg_reg;
  logic [NPORT-1:0] pinMeta_reg;
  logic [NPORT-1:0] pinSync_reg;
  logic [1:0]       intMeta_reg;
  logic [1:0]       intSync_reg;
  logic [1:0]       intPrev_reg;
  logic [1:0]       intLevel;
  logic [1:0]       intEvent;
  logic             wbReq;
  logic             wbHit;
  logic             wrEn;
  logic             rdStat;
  logic [31:0]      rdData;
  ppi_pkg::ppi_mode_e mode;
  ppi_pad_if #(.N(NPORT)) portIf ();
  ppi_pad_if #(.N(1))     txIf ();

  // byte-lane merge of a narrow register
  function automatic logic [5:0] merge6(input logic [5:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] sel);
    merge6 = sel[0] ? d[5:0] : old;
  endfunction

  function automatic logic [1:0] merge2(input logic [1:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] sel);
    merge2 = sel[0] ? d[1:0] : old;
  endfunction

  // bus decode; one wait state so ack drops between accesses
  assign wbReq  = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  always_comb begin
    wbHit  = 1'b1;
    rdData = 32'h0000_0000;
    case (wb_adr_i)
      `PPI_ADR_FUNC: rdData[NPORT-1:0] = funcTimer_reg;
      `PPI_ADR_DIR:  rdData[NPORT-1:0] = portDir_reg;
      `PPI_ADR_DATA: rdData[NPORT-1:0] = portData_reg;
      `PPI_ADR_PUR:  rdData[NPORT-1:0] = portPullEn_reg;
      `PPI_ADR_OD:   rdData[NPORT-1:0] = portOd_reg;
      `PPI_ADR_PIN:  rdData[NPORT-1:0] = pinSync_reg;
      `PPI_ADR_SPUD: rdData[1:0] = sysPud_reg;
      `PPI_ADR_ICTL: rdData[1:0] = intEdge_reg;
      `PPI_ADR_IST:  rdData[1:0] = intStat_reg;
      `PPI_ADR_IMSK: rdData[1:0] = intMask_reg;
      `PPI_ADR_TXC:  rdData[1:0] = txCfg_reg;
      default:       wbHit = 1'b0;
    endcase
  end
  assign wrEn   = wbReq & wbHit & wb_we_i;
  assign rdStat = wbReq & wbHit & ~wb_we_i & (wb_adr_i == `PPI_ADR_IST);

  // answer: ack for mapped, err for unmapped
  always_ff @(posedge mclk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wbReq & wbHit;
      wb_err_o <= wbReq & ~wbHit;
      wb_dat_o <= (wbReq & wbHit & ~wb_we_i) ? rdData : 32'h0000_0000;
    end
  end

  // port and mux control registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      funcTimer_reg  <= `PPI_RST_FUNC;
      portDir_reg    <= `PPI_RST_DIR;
      portData_reg   <= 6'h00;
      portPullEn_reg <= `PPI_RST_PUR;
      portOd_reg     <= `PPI_RST_OD;
    end else if (wrEn) begin
      case (wb_adr_i)
        `PPI_ADR_FUNC: funcTimer_reg <= merge6(funcTimer_reg, wb_dat_i,
                                               wb_sel_i);
        // per-bit direction
        `PPI_ADR_DIR:  portDir_reg <= merge6(portDir_reg, wb_dat_i,
                                             wb_sel_i);
        `PPI_ADR_DATA: portData_reg <= merge6(portData_reg, wb_dat_i,
                                              wb_sel_i);
        `PPI_ADR_PUR:  portPullEn_reg <= merge6(portPullEn_reg, wb_dat_i,
                                                wb_sel_i);
        `PPI_ADR_OD:   portOd_reg <= merge6(portOd_reg, wb_dat_i,
                                            wb_sel_i);
        default: ;
      endcase
    end
  end

  // system pull-up disable, interrupt control and transmit config
  always_ff @(posedge mclk) begin
    if (rst) begin
      sysPud_reg  <= 2'h0; // pull-ups on at reset
      intEdge_reg <= 2'h0;
      intMask_reg <= 2'h0;
      txCfg_reg   <= 2'h3; // open-drain, pull-up on
    end else if (wrEn) begin
      case (wb_adr_i)
        `PPI_ADR_SPUD: sysPud_reg <= merge2(sysPud_reg, wb_dat_i, wb_sel_i);
        `PPI_ADR_ICTL: intEdge_reg <= merge2(intEdge_reg, wb_dat_i,
                                             wb_sel_i);
        `PPI_ADR_IMSK: intMask_reg <= merge2(intMask_reg, wb_dat_i,
                                             wb_sel_i);
        `PPI_ADR_TXC:  txCfg_reg <= merge2(txCfg_reg, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
  end

  // pin input synchronisers; first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (rst) begin
      pinMeta_reg <= 6'h3f;
      pinSync_reg <= 6'h3f;
      intMeta_reg <= 2'h3;
      intSync_reg <= 2'h3;
    end else begin
      pinMeta_reg <= portPinIn;
      pinSync_reg <= pinMeta_reg;
      intMeta_reg <= {extIntReqBN, extIntReqAN};
      intSync_reg <= intMeta_reg;
    end
  end

  assign mode = lowPowerMode ? ppi_pkg::PPI_LOWP : ppi_pkg::PPI_RUN;

  // request path: raw pin in low-power mode so the request skips the synchroniser
  always_comb begin
    case (mode)
      ppi_pkg::PPI_LOWP: intLevel = ~{extIntReqBN, extIntReqAN};
      ppi_pkg::PPI_RUN:  intLevel = ~intSync_reg;
      default:           intLevel = ~intSync_reg;
    endcase
  end

  // level or falling edge, active low request
  assign intEvent = (intEdge_reg & ~intPrev_reg & intLevel)
                  | (~intEdge_reg & intLevel);

  // sticky status, set wins over read-clear
  always_comb begin
    intStat_next = rdStat ? 2'h0 : intStat_reg;
    intStat_next = intStat_next | intEvent;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      intPrev_reg <= 2'h0;
      intStat_reg <= 2'h0;
      extIntReq   <= 2'h0;
      irq         <= 1'b0;
    end else begin
      intPrev_reg <= intLevel;
      intStat_reg <= intStat_next;
      extIntReq   <= intEvent;
      irq         <= |(intStat_next & intMask_reg);
    end
  end

  // pad leaf control: port mode when function bit cleared
  always_comb begin
    for (int i = 0; i < NPORT; i++) begin
      portIf.isOut[i]  = funcTimer_reg[i] ? timerOutEn[i]
                                          : portDir_reg[i];
      portIf.outVal[i] = funcTimer_reg[i] ? timerOut[i] : portData_reg[i];
    end
  end
  assign portIf.openDrain = portOd_reg;
  assign portIf.pullEn    = portPullEn_reg;
  assign txIf.isOut       = 1'b1;
  assign txIf.outVal      = busTxData;
  assign txIf.openDrain   = txCfg_reg[`PPI_TXC_OD];
  assign txIf.pullEn      = txCfg_reg[`PPI_TXC_PUEN];

  ppi_pad_ctl u_port (.p(portIf));
  ppi_pad_ctl u_tx   (.p(txIf));

  // registered pad outputs; one cycle behind controls
  always_ff @(posedge mclk) begin
    if (rst) begin
      portPinOut  <= 6'h00;
      portPinOeN  <= 6'h3f;
      portPinPull <= 6'h3f;
      busTxOut    <= 1'b0;
      busTxOeN    <= 1'b1;
      busTxPull   <= 1'b1;
      busRxPull   <= 1'b1;
      extIntPull  <= 1'b1;
      timerIn     <= 6'h3f;
    end else begin
      portPinOut  <= portIf.padOut;
      portPinOeN  <= portIf.padOeN;
      portPinPull <= portIf.padPull;
      busTxOut    <= txIf.padOut[0];
      busTxOeN    <= txIf.padOeN[0];
      busTxPull   <= txIf.padPull[0];
      busRxPull   <= ~sysPud_reg[`PPI_SPUD_RX];
      extIntPull  <= ~sysPud_reg[`PPI_SPUD_IRQ];
      timerIn     <= pinSync_reg;
    end
  end

  a_od_low_nopull: assert property (@(posedge mclk) disable iff (rst)
    (portIf.isOut[0] && portIf.openDrain[0] && !portIf.outVal[0])
    |=> !portPinPull[0] && !portPinOeN[0])
    else $error("open-drain low kept pull-up");
  a_od_high_pull: assert property (@(posedge mclk) disable iff (rst)
    (portIf.isOut[0] && portIf.openDrain[0] && portIf.outVal[0])
    |=> portPinOeN[0] && (portPinPull[0] == $past(portPullEn_reg[0])))
    else $error("open-drain high pull wrong");
  a_pp_nopull: assert property (@(posedge mclk) disable iff (rst)
    (portIf.isOut[1] && !portIf.openDrain[1]) |=> !portPinPull[1])
    else $error("push-pull kept pull-up");
  a_tx_reset_cfg: assert property (@(posedge mclk)
    $fell(rst) |-> txCfg_reg == 2'h3)
    else $error("transmit pin not open-drain with pull-up");
  a_func_reset: assert property (@(posedge mclk)
    $fell(rst) |-> funcTimer_reg == 6'h3f && portPinOeN == 6'h3f)
    else $error("shared pins not timer inputs after reset");
  a_pur_clear: assert property (@(posedge mclk) disable iff (rst)
    (!portPullEn_reg[2]) |=> !portPinPull[2])
    else $error("cleared pull-up bit left pull-up on");
  a_lowp_async: assert property (@(posedge mclk) disable iff (rst)
    (lowPowerMode && intEdge_reg[0] == 1'b0 && !extIntReqAN)
    |=> extIntReq[0])
    else $error("low-power request not taken directly");
  a_run_sync: assert property (@(posedge mclk) disable iff (rst)
    (!lowPowerMode && !intEdge_reg[0]) [*3] ##0 $fell(extIntReqAN)
    ##0 intSync_reg[0] |=> !extIntReq[0])
    else $error("run request not synchronised");
  a_edge_once: assert property (@(posedge mclk) disable iff (rst)
    (intEdge_reg[1] && intPrev_reg[1] && intLevel[1]) |=> !extIntReq[1])
    else $error("edge mode repeated on held level");
  a_irq_pull: assert property (@(posedge mclk) disable iff (rst)
    sysPud_reg[`PPI_SPUD_IRQ] |=> !extIntPull)
    else $error("interrupt pull-up not disabled");
  a_rx_pull: assert property (@(posedge mclk) disable iff (rst)
    sysPud_reg[`PPI_SPUD_RX] |=> !busRxPull)
    else $error("receive pull-up not disabled");
  // pad flops lag the config by one cycle, so judge by last cycle's mode
  a_od_nodrive: assert property (@(posedge mclk) disable iff (rst)
    (busTxOeN == 1'b0 && $past(txCfg_reg[`PPI_TXC_OD]))
    |-> busTxOut == 1'b0)
    else $error("open-drain drove high");

  c_irq_fire: cover property (@(posedge mclk) disable iff (rst) $rose(irq));
  c_edge_a: cover property (@(posedge mclk) disable iff (rst)
    intEdge_reg[0] && extIntReq[0]);
  c_port_out: cover property (@(posedge mclk) disable iff (rst)
    !funcTimer_reg[0] && portDir_reg[0] && !portPinOeN[0]);
  c_lowp_wake: cover property (@(posedge mclk) disable iff (rst)
    lowPowerMode && extIntReq[1]);
endmodule

// *** src/ppi_pkg.sv ***
// types shared by the pad block files
// assumes the constants header is included by users
package ppi_pkg;
  typedef logic [5:0] ppi_port_t;
  typedef enum logic [1:0] {
    PPI_RUN  = 2'b01,
    PPI_LOWP = 2'b10
  } ppi_mode_e;
endpackage

// *** src/ppi_regs.svh ***
// register offsets, field positions and reset values of the pad block
// assumes a classic wishbone slave with 32-bit data, byte addresses
`ifndef PPI_REGS_SVH
`define PPI_REGS_SVH
`define PPI_ADR_FUNC    8'h00
`define PPI_ADR_DIR     8'h04
`define PPI_ADR_DATA    8'h08
`define PPI_ADR_PUR     8'h0c
`define PPI_ADR_OD      8'h10
`define PPI_ADR_PIN     8'h14
`define PPI_ADR_SPUD    8'h18
`define PPI_ADR_ICTL    8'h1c
`define PPI_ADR_IST     8'h20
`define PPI_ADR_IMSK    8'h24
`define PPI_ADR_TXC     8'h28
`define PPI_RST_FUNC    6'h3f
`define PPI_RST_DIR     6'h00
`define PPI_RST_PUR     6'h3f
`define PPI_RST_OD      6'h00
`define PPI_SPUD_RX     0
`define PPI_SPUD_IRQ    1
`define PPI_ICTL_EDGEA  0
`define PPI_ICTL_EDGEB  1
`define PPI_TXC_OD      0
`define PPI_TXC_PUEN    1
`endif

// *** test/ppi_ext_dev.sv ***
// model of the external parts wired to the shared pins and request lines
// assumes pad controls on mclk; undriven lines settle by their pull-up
`timescale 1ns/1ps
module ppi_ext_dev (
  input  wire logic       mclk,
  input  wire logic [5:0] pinOut,
  input  wire logic [5:0] pinOeN,
  input  wire logic [5:0] pinPull,
  input  wire logic [5:0] extEn,
  input  wire logic [5:0] extVal,
  input  wire logic       reqA,
  input  wire logic       reqB,
  input  wire logic       intPull,
  output logic      [5:0] pinIn,
  output logic            reqAN,
  output logic            reqBN
);
  logic tog;
  initial tog = 1'b0;
  // a released line with no pull wanders, it never keeps its last value
  always @(posedge mclk) tog <= ~tog;
  // pad level: device drive first, then external drive, then pull
  assign pinIn = (~pinOeN & pinOut) | (pinOeN & extEn & extVal)
               | (pinOeN & ~extEn & (pinPull | {6{tog}}));
  // requests pulled low only while service is wanted
  assign reqAN = reqA ? 1'b0 : (intPull | tog);
  assign reqBN = reqB ? 1'b0 : (intPull | tog);
endmodule

// *** test/ppi_pad_pullup_irq_tb.sv ***
// self-checking bench for the pad pull-up and request block
// assumes design files and the constants header are compiled first
`timescale 1ns/1ps
`include "ppi_regs.svh"
`define CHK(nm, e, a) begin nCompared++; if ((a) !== (e)) begin nFail++; \
  $display("[ERR] %s exp %h got %h", nm, e, a); end end
module ppi_pad_pullup_irq_tb;
  logic        mclk, rst, we, cyc, stb, ack, err, lpm, irq;
  logic        txData, txOut, txOeN, txPull, rxPull, iPull;
  logic        reqA, reqB, rAN, rBN;
  logic [1:0]  req;
  logic [7:0]  adr;
  logic [31:0] dat, dato;
  logic [5:0]  tOut, tEn, tIn, pIn, pOut, pOeN, pPull, extEn, extVal;
  int          nFail, nCompared, cycCnt;
  logic [35:0] rows [5] = '{
    {6'h3f, 6'h00, 6'h00, 6'h3f, 6'h00, 6'h00},
    {6'h3f, 6'h3f, 6'h00, 6'h3f, 6'h00, 6'h00},
    {6'h3f, 6'h0f, 6'h3f, 6'h3f, 6'h0f, 6'h0f},
    {6'h3f, 6'h3f, 6'h3f, 6'h05, 6'h3f, 6'h05},
    {6'h05, 6'h3f, 6'h00, 6'h30, 6'h3a, 6'h30}};
  logic [15:0] rstTab [5] = '{{`PPI_ADR_FUNC, 2'h0, `PPI_RST_FUNC},
    {`PPI_ADR_DIR, 2'h0, `PPI_RST_DIR}, {`PPI_ADR_PUR, 2'h0, `PPI_RST_PUR},
    {`PPI_ADR_OD, 2'h0, `PPI_RST_OD}, {`PPI_ADR_TXC, 8'h03}};

  ppi_pad_pullup_irq uut (.mclk(mclk), .rst(rst), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_sel_i(4'h1), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_dat_o(dato), .wb_ack_o(ack), .wb_err_o(err),
    .lowPowerMode(lpm), .timerOut(tOut), .timerOutEn(tEn), .timerIn(tIn),
    .portPinIn(pIn), .portPinOut(pOut), .portPinOeN(pOeN),
    .portPinPull(pPull), .busTxOut(txOut), .busTxOeN(txOeN),
    .busTxPull(txPull), .busTxData(txData), .busRxPull(rxPull),
    .extIntReqAN(rAN), .extIntReqBN(rBN), .extIntPull(iPull),
    .extIntReq(req), .irq(irq));
  ppi_ext_dev dev (.mclk(mclk), .pinOut(pOut), .pinOeN(pOeN),
    .pinPull(pPull), .extEn(extEn), .extVal(extVal), .reqA(reqA),
    .reqB(reqB), .intPull(iPull), .pinIn(pIn), .reqAN(rAN), .reqBN(rBN));

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic finalReport();
    $display("compared %0d, mismatches %0d", nCompared, nFail);
    if (nFail == 0 && nCompared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge mclk) begin
    cycCnt++;
    if (cycCnt == 5000) begin
      nFail++;
      finalReport();
    end
  end

  // one classic cycle; the request stands until ack or err is sampled
  task automatic wbc(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    @(posedge mclk iff (ack | err));
    q = dato;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [5:0] d);
    logic [31:0] q;
    logic        e;
    wbc(1'b1, a, {26'h0, d}, q, e);
  endtask

  // let the launching edge land before looking
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic chkReset();
    `CHK("oen", 6'h3f, pOeN)
    `CHK("pull", 6'h3f, pPull)
    `CHK("txoen", 1'b1, txOeN)
    `CHK("txpull", 1'b1, txPull)
    `CHK("rxpull", 1'b1, rxPull)
    `CHK("intpull", 1'b1, iPull)
    `CHK("tin", 6'h3f, tIn)
    `CHK("irq", 2'b00, {irq, req[0]})
  endtask

  initial begin
    logic [31:0] q;
    logic        e;
    logic [3:0]  cnt;
    {we, cyc, stb, adr, dat, lpm, tOut, tEn} = '0;
    {extEn, extVal, reqA, reqB} = '0;
    rst = 1'b1;
    txData = 1'b1;
    tick(5);
    chkReset();
    @(posedge mclk) rst <= 1'b0;
    foreach (rstTab[i]) begin
      wbc(1'b0, rstTab[i][15:8], 32'h0, q, e);
      `CHK("rstreg", {24'h0, rstTab[i][7:0]}, q)
    end
    // shared pins still belong to the timers here
    @(posedge mclk) tEn <= 6'h3f;
    tOut <= 6'h2a;
    tick(2);
    `CHK("tmrout", 12'h02a, {pOeN, pOut})
    @(posedge mclk) tEn <= 6'h00;
    wr(`PPI_ADR_FUNC, 6'h00);
    // table rows: dir, data, open-drain, pull enable, expected oen, pull
    foreach (rows[i]) begin
      wr(`PPI_ADR_DIR, rows[i][35:30]);
      wr(`PPI_ADR_DATA, rows[i][29:24]);
      wr(`PPI_ADR_OD, rows[i][23:18]);
      wr(`PPI_ADR_PUR, rows[i][17:12]);
      tick(2);
      `CHK("rowoen", rows[i][11:6], pOeN)
      `CHK("rowpull", rows[i][5:0], pPull)
      `CHK("rowout", rows[i][29:24] & ~rows[i][11:6], pOut & ~pOeN)
    end
    @(posedge mclk) extEn <= 6'h02;
    tick(4);
    wbc(1'b0, `PPI_ADR_PIN, 32'h0, q, e);
    `CHK("pin", 6'h35, q[5:0] & 6'h37)
    `CHK("tmrin", 6'h35, tIn & 6'h37)
    // transmit pad: open-drain low, open-drain high unpulled, push-pull
    @(posedge mclk) txData <= 1'b0;
    tick(2);
    `CHK("txodlo", 3'b000, {txOeN, txPull, txOut})
    @(posedge mclk) txData <= 1'b1;
    wr(`PPI_ADR_TXC, 6'h01);
    tick(2);
    `CHK("txodhi", 2'b10, {txOeN, txPull})
    wr(`PPI_ADR_TXC, 6'h00);
    tick(2);
    `CHK("txpp", 3'b001, {txOeN, txPull, txOut})
    wr(`PPI_ADR_SPUD, 6'h03);
    tick(2);
    `CHK("spud", 2'b00, {rxPull, iPull})
    wr(`PPI_ADR_SPUD, 6'h00);
    wbc(1'b0, 8'h3c, 32'h0, q, e);
    `CHK("unmapped", 1'b1, e)
    // level requests, run mode, through the synchroniser
    wr(`PPI_ADR_IMSK, 6'h03);
    tick(4);
    wbc(1'b0, `PPI_ADR_IST, 32'h0, q, e);
    @(posedge mclk) reqA <= 1'b1;
    tick(1);
    `CHK("syncA1", 1'b0, req[0])
    tick(2);
    `CHK("syncA3", 2'b11, {irq, req[0]})
    @(posedge mclk) reqA <= 1'b0;
    tick(4);
    wbc(1'b0, `PPI_ADR_IST, 32'h0, q, e);
    `CHK("stat", 32'h1, q)
    wbc(1'b0, `PPI_ADR_IST, 32'h0, q, e);
    tick(1);
    `CHK("statclr", 33'h0, {irq, q})
    // masked request sets status and the request output but never irq
    wr(`PPI_ADR_IMSK, 6'h00);
    @(posedge mclk) reqB <= 1'b1;
    tick(5);
    `CHK("masked", 2'b01, {irq, req[1]})
    @(posedge mclk) reqB <= 1'b0;
    tick(4);
    wbc(1'b0, `PPI_ADR_IST, 32'h0, q, e);
    `CHK("statB", 32'h2, q)
    // low-power mode takes the pin without the synchroniser
    @(posedge mclk) lpm <= 1'b1;
    reqA <= 1'b1;
    tick(1);
    `CHK("async", 1'b1, req[0])
    @(posedge mclk) reqA <= 1'b0;
    tick(2);
    @(posedge mclk) lpm <= 1'b0;
    // falling-edge mode: one pulse however long the pin stays low
    wr(`PPI_ADR_ICTL, 6'h03);
    tick(4);
    @(posedge mclk) reqB <= 1'b1;
    cnt = 4'h0;
    repeat (8) begin
      tick(1);
      cnt = cnt + {3'h0, req[1]};
    end
    `CHK("edge", 4'h1, cnt)
    @(posedge mclk) reqB <= 1'b0;
    @(posedge mclk) rst <= 1'b1;
    tick(2);
    chkReset();
    @(posedge mclk) rst <= 1'b0;
    wbc(1'b0, `PPI_ADR_FUNC, 32'h0, q, e);
    `CHK("rstfunc", {26'h0, `PPI_RST_FUNC}, q)
    finalReport();
  end
endmodule
